// [flt_pkg.sv]
// Package for the capture and fault input filter control block.
// Assumes a 32-bit AHB-Lite slave port and a 10 MHz hclk.
package flt_pkg;
    // Register byte offsets
    localparam logic [7:0] CAP_FILT_OFF    = 8'h78;
    localparam logic [7:0] FAULT_CTRL_OFF  = 8'h7C;
    localparam logic [7:0] MODE_OFF        = 8'h54;
    localparam logic [7:0] FAULT_STAT_OFF  = 8'h80;
    // Field positions
    localparam int FVAL_W          = 4;
    localparam int CH0_FVAL_LSB    = 0;
    localparam int CH1_FVAL_LSB    = 4;
    localparam int CH2_FVAL_LSB    = 8;
    localparam int CH3_FVAL_LSB    = 12;
    localparam int IN_EN_LSB       = 0;
    localparam int FLT_EN_LSB      = 4;
    localparam int FFVAL_LSB       = 8;
    localparam int WP_DISABLE_BIT  = 2;
    localparam int FAULT_CTL_BIT   = 0;
    localparam int NUM_FAULTS      = 4;
    localparam int NUM_CHANNELS    = 8;
    localparam int NUM_FILT_CH     = 4;
    // Reset values
    localparam logic [15:0] CAP_FILT_RST   = 16'h0000;
    localparam logic [11:0] FAULT_CTRL_RST = 12'h000;
    localparam logic [2:0]  MODE_RST       = 3'h4;
    // Filter clock counts are in hclk cycles per unit value
    localparam logic [5:0]  FILT_SCALE     = 6'h04;
    // AHB codes
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ     = 2'h3;
endpackage

// [glitch_filter.sv]
// Single-input glitch filter: output follows input once stable long enough.
// Assumes input already synchronous to hclk.
`timescale 1ns/1ns
module glitch_filter (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       din,
    input  wire logic [3:0] fval,
    input  wire logic       enable,
    output logic            dout
);
    import flt_pkg::*;

    logic [5:0] cnt_ff;
    logic [5:0] nxt_cnt;
    logic       q_ff;
    logic       nxt_q;
    logic [5:0] limit;

    // Stability count; zero value or disabled passes straight through
    always_comb begin
        limit = 6'({2'h0, fval} * FILT_SCALE);
        nxt_cnt = 6'h00;
        nxt_q = q_ff;
        if (!enable || fval == 4'h0) begin
            nxt_q = din;
        end else if (din == q_ff) begin
            nxt_cnt = 6'h00;
        end else if (cnt_ff + 6'h01 >= limit) begin
            nxt_q = din;
        end else begin
            nxt_cnt = cnt_ff + 6'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff <= 6'h00;
            q_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            q_ff <= nxt_q;
        end
    end

    assign dout = q_ff;
endmodule // glitch_filter

// [input_filter_ctrl.sv]
// Capture channel and fault input filter control with an AHB-Lite slave.
// Assumes one hclk domain and inputs synchronous to it.
//
// Behaviour
// - channels four to seven pass unfiltered
// - channels three..one filter values at 15:4
// - zero filter value passes input straight through
// - fault control reserved bits read zero
// - one shared fault filter value, zero disables
// - bits 7:4 enable fault input filters
// - bits 3:0 enable fault inputs
// - enable bits writable only when protection disabled
// - detect flag needs control, enable, fault
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ns
module input_filter_ctrl (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  chan_in,
    input  wire logic [3:0]  fault_in,
    output logic      [7:0]  chan_out,
    output logic      [3:0]  fault_flags
);
    import flt_pkg::*;

    logic [15:0] cap_filt_ff;
    logic [15:0] nxt_cap_filt;
    logic [11:0] fault_ctrl_ff;
    logic [11:0] nxt_fault_ctrl;
    logic [2:0]  mode_ff;
    logic [2:0]  nxt_mode;
    logic [3:0]  flag_ff;
    logic [3:0]  nxt_flag;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [7:0]  chan_ff;
    logic [7:0]  nxt_chan;
    logic        ready_ff;
    logic        nxt_ready;
    logic        resp_ff;
    logic        nxt_resp;
    logic [3:0]  fflt_out;
    logic [3:0]  cflt_out;
    logic        wr_pend_ff;
    logic        nxt_wr_pend;
    logic [7:0]  wr_addr_ff;
    logic [7:0]  nxt_wr_addr;
    logic        rd_go;
    logic        wp_open;
    logic [3:0]  fault_en;
    logic [3:0]  ffilt_en;

    // Returns one channel's filter value from the capture filter word
    function automatic logic [3:0] chan_fval(input logic [15:0] w,
                                             input int ch);
        chan_fval = w[ch*FVAL_W +: FVAL_W];
    endfunction

    // Word address match inside the block's window
    function automatic logic addr_is(input logic [7:0] a,
                                     input logic [7:0] off);
        addr_is = (a[7:2] == off[7:2]);
    endfunction

    assign rd_go = hsel && hready && htrans[1] && !hwrite;
    assign wp_open = mode_ff[WP_DISABLE_BIT];
    assign fault_en = fault_ctrl_ff[IN_EN_LSB +: NUM_FAULTS];
    assign ffilt_en = fault_ctrl_ff[FLT_EN_LSB +: NUM_FAULTS];

    // Channel filters; only channels 0..3 have one
    genvar g;
    generate
        for (g = 0; g < NUM_FILT_CH; g++) begin : g_chan
            glitch_filter u_cflt (
                .hclk    (hclk),
                .hresetn (hresetn),
                .din     (chan_in[g]),
                .fval    (chan_fval(cap_filt_ff, g)),
                .enable  (1'b1),
                .dout    (cflt_out[g])
            );
        end
        for (g = 0; g < NUM_FAULTS; g++) begin : g_fault
            glitch_filter u_fflt (
                .hclk    (hclk),
                .hresetn (hresetn),
                .din     (fault_in[g] & fault_en[g]),
                .fval    (fault_ctrl_ff[FFVAL_LSB +: FVAL_W]),
                .enable  (ffilt_en[g]),
                .dout    (fflt_out[g])
            );
        end
    endgenerate

    // Write capture then register update in the data phase
    always_comb begin
        nxt_wr_pend = hsel && hready && htrans[1] && hwrite;
        nxt_wr_addr = wr_pend_ff ? wr_addr_ff : 8'h00;
        if (hsel && hready && htrans[1]) begin
            nxt_wr_addr = haddr[7:0];
        end
        nxt_cap_filt = cap_filt_ff;
        nxt_fault_ctrl = fault_ctrl_ff;
        nxt_mode = mode_ff;
        if (wr_pend_ff) begin
            if (addr_is(wr_addr_ff, CAP_FILT_OFF)) begin
                nxt_cap_filt = hwdata[15:0];
            end
            if (addr_is(wr_addr_ff, MODE_OFF)) begin
                nxt_mode = hwdata[2:0];
            end
            if (addr_is(wr_addr_ff, FAULT_CTRL_OFF)) begin
                // Filter value has no protection; enables do
                nxt_fault_ctrl[11:8] = hwdata[11:8];
                if (wp_open) begin
                    nxt_fault_ctrl[7:0] = hwdata[7:0];
                end
            end
        end
    end

    // Sticky fault flags; set wins over a software clear of zero
    always_comb begin
        nxt_flag = flag_ff;
        if (wr_pend_ff && addr_is(wr_addr_ff, FAULT_STAT_OFF)) begin
            nxt_flag = flag_ff & hwdata[3:0];
        end
        for (int i = 0; i < NUM_FAULTS; i++) begin
            if (mode_ff[FAULT_CTL_BIT] && fault_en[i] && fflt_out[i]) begin
                nxt_flag[i] = 1'b1;
            end
        end
    end

    // Read data, registered one cycle after the address phase
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (rd_go) begin
            if (addr_is(haddr[7:0], CAP_FILT_OFF)) begin
                nxt_rdata = {16'h0000, cap_filt_ff};
            end else if (addr_is(haddr[7:0], FAULT_CTRL_OFF)) begin
                nxt_rdata = {20'h00000, fault_ctrl_ff};
            end else if (addr_is(haddr[7:0], MODE_OFF)) begin
                nxt_rdata = {29'h0000_0000, mode_ff};
            end else if (addr_is(haddr[7:0], FAULT_STAT_OFF)) begin
                nxt_rdata = {28'h000_0000, flag_ff};
            end
        end
    end

    // Upper channels bypass any filter; no wait states, always OKAY
    always_comb begin
        nxt_chan = {chan_in[7:4], cflt_out};
        nxt_ready = 1'b1;
        nxt_resp = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_filt_ff <= CAP_FILT_RST;
            fault_ctrl_ff <= FAULT_CTRL_RST;
            mode_ff <= MODE_RST;
            flag_ff <= 4'h0;
            rdata_ff <= 32'h0000_0000;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            chan_ff <= 8'h00;
            ready_ff <= 1'b1;
            resp_ff <= 1'b0;
        end else begin
            cap_filt_ff <= nxt_cap_filt;
            fault_ctrl_ff <= nxt_fault_ctrl;
            mode_ff <= nxt_mode;
            flag_ff <= nxt_flag;
            rdata_ff <= nxt_rdata;
            wr_pend_ff <= nxt_wr_pend;
            wr_addr_ff <= nxt_wr_addr;
            chan_ff <= nxt_chan;
            ready_ff <= nxt_ready;
            resp_ff <= nxt_resp;
        end
    end

    assign hrdata = rdata_ff;
    assign hreadyout = ready_ff;
    assign hresp = resp_ff;
    assign chan_out = chan_ff;
    assign fault_flags = flag_ff;

    // Upper channels follow input one cycle later
    upper_pass_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        chan_out[7:4] == $past(chan_in[7:4]))
        else $error("upper channel not passed through");
    // Zero value at the filter's edge: filter stage plus output register
    zero_pass_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (cap_filt_ff[3:0] == 4'h0)
        |-> ##2 chan_out[0] == $past(chan_in[0], 2))
        else $error("unfiltered channel zero wrong");
    // Reserved bits read zero
    resv_zero_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $past(rd_go && addr_is(haddr[7:0], FAULT_CTRL_OFF))
        |-> hrdata[31:12] == 20'h00000)
        else $error("reserved fault bits nonzero");
    // Protected write leaves enables alone
    wp_hold_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $past(wr_pend_ff && !wp_open) |-> $stable(fault_ctrl_ff[7:0]))
        else $error("protected enables changed");
    // Open write loads enables
    wp_load_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_ff && wp_open && addr_is(wr_addr_ff, FAULT_CTRL_OFF)
        |=> fault_ctrl_ff[7:0] == $past(hwdata[7:0]))
        else $error("enable write lost");
    // Flag rises only with cause
    flag_cause_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(flag_ff[0]) |-> $past(mode_ff[FAULT_CTL_BIT] && fault_en[0]))
        else $error("flag set without enable");
    // Fault filter value written unprotected
    ffval_load_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_ff && addr_is(wr_addr_ff, FAULT_CTRL_OFF)
        |=> fault_ctrl_ff[11:8] == $past(hwdata[11:8]))
        else $error("fault filter value lost");
    // Channel value write lands in place
    chan_load_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_ff && addr_is(wr_addr_ff, CAP_FILT_OFF)
        |=> cap_filt_ff == $past(hwdata[15:0]))
        else $error("channel filter write lost");
endmodule // input_filter_ctrl

// [input_filter_ctrl_test.sv]
// Self-checking bench for the capture and fault filter control block.
// Assumes flt_pkg offsets and a slave that answers within 20 cycles.
`timescale 1ns/1ns
module input_filter_ctrl_test;
    import flt_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  ch_req, chan_in, chan_out;
    logic [3:0]  flt_req, fault_in, fault_flags;
    int          mismatches, total_checks;

    // Bus ready loops back; a single slave owns hready
    input_filter_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .chan_in(chan_in),
        .fault_in(fault_in), .chan_out(chan_out),
        .fault_flags(fault_flags));
    pin_model u_pins (.hclk(hclk), .ch_req(ch_req), .flt_req(flt_req),
        .chan_in(chan_in), .fault_in(fault_in));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // Bounded wait for ready; a hung slave ends the run
    task automatic wait_ack;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                mismatches++;
                wrap_up();
            end
            @(posedge hclk);
        end
    endtask

    // One single word transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= {24'h000000, a};
        hwrite <= w;
        wait_ack();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ack();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] exp);
        xfer(1'b0, a, 32'h00000000);
        check(nm, rd, exp);
        check("hresp", {31'h00000000, hresp}, 32'h00000000);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask

    initial begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        ch_req = 8'h00;
        flt_req = 4'h0;
        mismatches = 0;
        total_checks = 0;
        idle(12);
        hresetn <= 1'b1;
        rdchk("cap_rst", CAP_FILT_OFF, {16'h0000, CAP_FILT_RST});
        rdchk("flt_rst", FAULT_CTRL_OFF, {20'h00000, FAULT_CTRL_RST});
        rdchk("unmapped", 8'h40, 32'h00000000);
        $display("test reset done");
        wr(CAP_FILT_OFF, 32'h00004321);
        rdchk("cap_fields", CAP_FILT_OFF, 32'h00004321);
        // Longest filter: short pulse must not reach channels 3..0
        wr(CAP_FILT_OFF, 32'h0000FFFF);
        ch_req <= 8'hFF;
        idle(6);
        check("chan_hi", {24'h000000, chan_out}, 32'h000000F0);
        ch_req <= 8'h00;
        idle(4);
        wr(CAP_FILT_OFF, 32'h00000000);
        ch_req <= 8'h0F;
        idle(6);
        check("chan_bypass", {24'h000000, chan_out}, 32'h0000000F);
        ch_req <= 8'h00;
        $display("test channels done");
        wr(FAULT_CTRL_OFF, 32'hFFFFFFFF);
        rdchk("flt_all", FAULT_CTRL_OFF, 32'h00000FFF);
        wr(MODE_OFF, 32'h00000000);
        wr(FAULT_CTRL_OFF, 32'h00000000);
        rdchk("flt_prot", FAULT_CTRL_OFF, 32'h000000FF);
        wr(MODE_OFF, 32'h00000004);
        wr(FAULT_CTRL_OFF, 32'h00000001);
        // Fault control off: an enabled input must not flag
        flt_req <= 4'hF;
        idle(4);
        flt_req <= 4'h0;
        idle(3);
        check("flag_off", {28'h0, fault_flags}, 32'h00000000);
        wr(MODE_OFF, 32'h00000005);
        flt_req <= 4'hF;
        idle(4);
        flt_req <= 4'h0;
        idle(3);
        check("flag_in0", {28'h0, fault_flags}, 32'h00000001);
        wr(FAULT_STAT_OFF, 32'h00000000);
        wr(MODE_OFF, 32'h00000004);
        wr(FAULT_CTRL_OFF, 32'h00000F22);
        wr(MODE_OFF, 32'h00000005);
        // Shared filter at 15 swallows a short pulse on fault 1
        flt_req <= 4'h2;
        idle(5);
        flt_req <= 4'h0;
        idle(3);
        check("flag_filt", {28'h0, fault_flags}, 32'h00000000);
        flt_req <= 4'h2;
        idle(70);
        check("flag_long", {28'h0, fault_flags}, 32'h00000002);
        flt_req <= 4'h0;
        $display("test faults done");
        wrap_up();
    end
endmodule // input_filter_ctrl_test

// [pin_model.sv]
// Model of the external capture and fault input pins.
// Assumes the bench asks for new levels right after rising hclk.
`timescale 1ns/1ns
module pin_model (
    input  wire logic       hclk,
    input  wire logic [7:0] ch_req,
    input  wire logic [3:0] flt_req,
    output logic      [7:0] chan_in,
    output logic      [3:0] fault_in
);
    // Pins follow a request one edge late, as a board driver would
    always_ff @(posedge hclk) begin
        chan_in  <= ch_req;
        fault_in <= flt_req;
    end
endmodule // pin_model
